// >>> hdl/receiver_shutdown_sequencer.sv
/*
  receiver shut-down sequencer: takes shut-down configuration packets,
  steps the receiver control lines through up to two timed stages and
  then to the receiver-off setting when decoding is switched off.
  assumes packets arrive as whole 32-bit words from an spi receiver on
  the same clock, and that the receiver-on and receiver-off settings come
  from the surrounding decoder logic.
*/
`timescale 1ns/1ns
`default_nettype none

module receiver_shutdown_sequencer
  import rx_shutdown_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = HOLD_UNIT_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // configuration packets
  input wire logic packet_valid,
  input wire logic [31:0] packet_data,
  // decoder control
  input wire logic decoder_run_bit,
  input wire logic receiver_active,
  input wire logic [LINES_WIDTH-1:0] receiver_on_lines,
  input wire logic [LINES_WIDTH-1:0] receiver_off_lines,
  // battery pin
  input wire logic battery_low_input,
  // receiver control lines and status
  output logic [LINES_WIDTH-1:0] rx_control_lines,
  output logic shutdown_busy,
  output logic receiver_off,
  output logic warmup_permit,
  output logic battery_sample_strobe,
  output logic battery_low_sampled
);

  typedef enum logic [1:0] {
    st_idle,
    st_stage_one,
    st_stage_two,
    st_off
  } seq_state_t;

  // configuration registers
  stage_cfg_t cfg_one_q;
  stage_cfg_t cfg_one_d;
  stage_cfg_t cfg_two_q;
  stage_cfg_t cfg_two_d;
  stage_cfg_t packet_cfg;
  logic packet_is_shutdown;

  // sequencer state
  seq_state_t state_q;
  seq_state_t state_d;
  stage_cfg_t active_q;
  stage_cfg_t active_d;
  logic [LINES_WIDTH-1:0] lines_q;
  logic [LINES_WIDTH-1:0] lines_d;
  logic run_prev_q;
  logic run_prev_d;
  logic battery_q;
  logic battery_d;
  logic strobe_q;
  logic strobe_d;
  logic timer_start;
  logic timer_expired;
  logic off_request;
  logic probe_now;

  // battery pin synchroniser
  logic battery_meta_q;
  logic battery_sync_q;

  always_comb
  begin
    packet_is_shutdown = packet_valid &&
      (packet_data[PKT_ID_MSB:PKT_ID_LSB] == PKT_ID_SHUTDOWN);
    // reserved bits are not checked; only the named fields are taken
    packet_cfg.step_enable = packet_data[PKT_STEP_ENABLE_BIT];
    packet_cfg.low_battery_probe = packet_data[PKT_PROBE_BIT];
    packet_cfg.control_line_value = packet_data[PKT_LINES_MSB:PKT_LINES_LSB];
    packet_cfg.hold_interval = packet_data[PKT_HOLD_MSB:PKT_HOLD_LSB];
  end

  always_comb
  begin
    cfg_one_d = cfg_one_q;
    cfg_two_d = cfg_two_q;
    if (packet_is_shutdown)
    begin
      if (packet_data[PKT_TIER_BIT])
      begin
        cfg_two_d = packet_cfg;
      end
      else
      begin
        cfg_one_d = packet_cfg;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cfg_one_q <= STAGE_CFG_RESET;
      cfg_two_q <= STAGE_CFG_RESET;
    end
    else if (clock_enable)
    begin
      cfg_one_q <= cfg_one_d;
      cfg_two_q <= cfg_two_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      battery_meta_q <= 1'b0;
      battery_sync_q <= 1'b0;
    end
    else if (clock_enable)
    begin
      battery_meta_q <= battery_low_input;
      battery_sync_q <= battery_meta_q;
    end
  end

  hold_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) stage_timer (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .start(timer_start),
    .code(active_d.hold_interval),
    .expired(timer_expired)
  );

  // a falling run bit only matters while the receiver is on or warming up
  assign off_request = run_prev_q && !decoder_run_bit && receiver_active;

  always_comb
  begin
    state_d = state_q;
    active_d = active_q;
    lines_d = lines_q;
    run_prev_d = decoder_run_bit;
    battery_d = battery_q;
    timer_start = 1'b0;
    probe_now = 1'b0;
    case (state_q)
      st_idle:
      begin
        lines_d = receiver_on_lines;
        if (off_request)
        begin
          if (cfg_one_q.step_enable)
          begin
            state_d = st_stage_one;
            active_d = cfg_one_q;
            lines_d = cfg_one_q.control_line_value;
            timer_start = 1'b1;
          end
          else
          begin
            // stage two is ignored when stage one is off
            state_d = st_off;
            lines_d = receiver_off_lines;
          end
        end
      end
      st_stage_one:
      begin
        lines_d = active_q.control_line_value;
        if (timer_expired)
        begin
          probe_now = active_q.low_battery_probe;
          if (cfg_two_q.step_enable)
          begin
            state_d = st_stage_two;
            active_d = cfg_two_q;
            lines_d = cfg_two_q.control_line_value;
            timer_start = 1'b1;
          end
          else
          begin
            state_d = st_off;
            lines_d = receiver_off_lines;
          end
        end
      end
      st_stage_two:
      begin
        lines_d = active_q.control_line_value;
        if (timer_expired)
        begin
          probe_now = active_q.low_battery_probe;
          state_d = st_off;
          lines_d = receiver_off_lines;
        end
      end
      st_off:
      begin
        lines_d = receiver_off_lines;
        // warm-up is handed back only once the whole sequence is over
        if (decoder_run_bit)
        begin
          state_d = st_idle;
          lines_d = receiver_on_lines;
        end
      end
      default:
      begin
        state_d = st_idle;
        lines_d = receiver_on_lines;
      end
    endcase
    if (probe_now)
    begin
      battery_d = battery_sync_q;
    end
    strobe_d = probe_now;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= st_idle;
      active_q <= STAGE_CFG_RESET;
      lines_q <= RESET_LINES;
      run_prev_q <= 1'b0;
      battery_q <= 1'b0;
      strobe_q <= 1'b0;
    end
    else if (clock_enable)
    begin
      state_q <= state_d;
      active_q <= active_d;
      lines_q <= lines_d;
      run_prev_q <= run_prev_d;
      battery_q <= battery_d;
      strobe_q <= strobe_d;
    end
  end

  assign rx_control_lines = lines_q;
  assign shutdown_busy = (state_q == st_stage_one) || (state_q == st_stage_two);
  assign receiver_off = (state_q == st_off);
  // the warm-up sequencer outside must wait on this before it starts
  assign warmup_permit = decoder_run_bit && !shutdown_busy;
  assign battery_sample_strobe = strobe_q;
  assign battery_low_sampled = battery_q;

endmodule // receiver_shutdown_sequencer

`default_nettype wire

// >>> hdl/rx_shutdown_pkg.sv
/*
  shared constants and types for the receiver shut-down sequencer:
  packet layout, reset values of the stage settings and timing counts.
  assumes a 10 mhz decoder clock.
*/
package rx_shutdown_pkg;

  // packet layout, bit positions in the 32-bit configuration packet
  localparam int unsigned PKT_ID_MSB = 31;
  localparam int unsigned PKT_ID_LSB = 25;
  localparam logic [6:0] PKT_ID_SHUTDOWN = 7'h0d;
  localparam int unsigned PKT_TIER_BIT = 24;
  localparam int unsigned PKT_STEP_ENABLE_BIT = 23;
  localparam int unsigned PKT_PROBE_BIT = 19;
  localparam int unsigned PKT_LINES_MSB = 15;
  localparam int unsigned PKT_LINES_LSB = 8;
  localparam int unsigned PKT_HOLD_MSB = 5;
  localparam int unsigned PKT_HOLD_LSB = 0;

  // packet identity codes as whole top bytes
  localparam logic [7:0] STAGE_ONE_CONFIG_ID = 8'h1a;
  localparam logic [7:0] STAGE_TWO_CONFIG_ID = 8'h1b;

  localparam int unsigned HOLD_WIDTH = 6;
  localparam int unsigned LINES_WIDTH = 8;

  // reset values of a stage setting
  localparam logic RESET_STEP_ENABLE = 1'b0;
  localparam logic RESET_PROBE = 1'b0;
  localparam logic [LINES_WIDTH-1:0] RESET_LINES = 8'h00;
  localparam logic [HOLD_WIDTH-1:0] RESET_HOLD = 6'h01;
  localparam logic [HOLD_WIDTH-1:0] HOLD_MIN = 6'h01;

  // timing
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned HOLD_UNIT_US = 625;
  localparam int unsigned HOLD_UNIT_CYCLES = (HOLD_UNIT_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned UNIT_COUNT_WIDTH = 20;

  typedef struct packed {
    logic step_enable;
    logic low_battery_probe;
    logic [LINES_WIDTH-1:0] control_line_value;
    logic [HOLD_WIDTH-1:0] hold_interval;
  } stage_cfg_t;

  localparam stage_cfg_t STAGE_CFG_RESET = '{
    step_enable: RESET_STEP_ENABLE,
    low_battery_probe: RESET_PROBE,
    control_line_value: RESET_LINES,
    hold_interval: RESET_HOLD
  };

endpackage

// >>> hdl/hold_timer.sv
/*
  hold timer: after a start pulse, counts code times unit_cycles clock
  cycles and then gives a one-cycle expired pulse.
  assumes start comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module hold_timer
  import rx_shutdown_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = HOLD_UNIT_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // control
  input wire logic start,
  input wire logic [HOLD_WIDTH-1:0] code,
  output logic expired
);

  localparam logic [UNIT_COUNT_WIDTH-1:0] UNIT_LAST = UNIT_COUNT_WIDTH'(UNIT_CYCLES - 1);

  logic running_q;
  logic running_d;
  logic [UNIT_COUNT_WIDTH-1:0] unit_q;
  logic [UNIT_COUNT_WIDTH-1:0] unit_d;
  logic [HOLD_WIDTH-1:0] left_q;
  logic [HOLD_WIDTH-1:0] left_d;
  logic expired_q;
  logic expired_d;

  always_comb
  begin
    running_d = running_q;
    unit_d = unit_q;
    left_d = left_q;
    expired_d = 1'b0;
    if (start)
    begin
      running_d = 1'b1;
      unit_d = '0;
      // a zero code is outside the legal range; it is held as the shortest step
      left_d = (code == '0) ? HOLD_MIN : code;
    end
    else if (running_q)
    begin
      if (unit_q == UNIT_LAST)
      begin
        unit_d = '0;
        if (left_q == HOLD_MIN)
        begin
          running_d = 1'b0;
          expired_d = 1'b1;
        end
        else
        begin
          left_d = left_q - HOLD_MIN;
        end
      end
      else
      begin
        unit_d = unit_q + UNIT_COUNT_WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      running_q <= 1'b0;
      unit_q <= '0;
      left_q <= HOLD_MIN;
      expired_q <= 1'b0;
    end
    else if (clock_enable)
    begin
      running_q <= running_d;
      unit_q <= unit_d;
      left_q <= left_d;
      expired_q <= expired_d;
    end
  end

  assign expired = expired_q & clock_enable;

endmodule // hold_timer

`default_nettype wire

// >>> verification/shutdown_checker_properties.sv
/* port assertions for the shut-down sequencer.
   assumes receiver_off_lines is held steady by the bench. */
`timescale 1ns/1ns
`default_nettype none
module shutdown_checker
#(parameter int unsigned UNIT_CYCLES = 2)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // decoder side
  input wire logic decoder_run_bit,
  input wire logic receiver_active,
  input wire logic [7:0] receiver_off_lines,
  // outputs
  input wire logic [7:0] rx_control_lines,
  input wire logic shutdown_busy,
  input wire logic receiver_off,
  input wire logic warmup_permit,
  input wire logic battery_sample_strobe
);
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  always_comb busy_cnt_d = (reset || !shutdown_busy) ? 16'h0000 : busy_cnt_q + 16'h0001;
  always_ff @(posedge clock) busy_cnt_q <= busy_cnt_d;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_warm; warmup_permit == (decoder_run_bit && !shutdown_busy); endproperty
  a_warm: assert property (p_warm) else $error("warm-up permitted while busy");
  // reset-time run level is not a falling edge
  property p_start; clock_enable && $past(clock_enable) && !$past(reset)
    && $fell(decoder_run_bit) && receiver_active && !shutdown_busy && !receiver_off
    |=> shutdown_busy || receiver_off; endproperty
  a_start: assert property (p_start) else $error("shut-down not started");
  property p_off; receiver_off |-> rx_control_lines == receiver_off_lines; endproperty
  a_off: assert property (p_off) else $error("off setting wrong");
  property p_exit; clock_enable && receiver_off && decoder_run_bit |=> !receiver_off; endproperty
  a_exit: assert property (p_exit) else $error("off state kept");
  property p_excl; !(shutdown_busy && receiver_off); endproperty
  a_excl: assert property (p_excl) else $error("busy while off");
  property p_hold; $fell(shutdown_busy) |-> busy_cnt_q >= UNIT_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("stage too short");
  property p_probe; battery_sample_strobe && $past(clock_enable) |-> $past(shutdown_busy);
  endproperty
  a_probe: assert property (p_probe) else $error("probe outside stage");
  property p_rst; $past(reset) |-> rx_control_lines == 8'h00 && !shutdown_busy
    && !receiver_off; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_keep; shutdown_busy && decoder_run_bit |=> shutdown_busy || receiver_off; endproperty
  a_keep: assert property (p_keep) else $error("sequence abandoned");
endmodule // shutdown_checker
bind receiver_shutdown_sequencer shutdown_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u (.clock,
  .reset, .clock_enable, .decoder_run_bit, .receiver_active, .receiver_off_lines, .rx_control_lines,
  .shutdown_busy, .receiver_off, .warmup_permit, .battery_sample_strobe);
`default_nettype wire

// >>> verification/host_packet_model.sv
/* host model: writes 32-bit shut-down packets.
   assumes the caller waits for each write to finish. */
`timescale 1ns/1ns
`default_nettype none
module host_packet_model
(
  // packet bus
  input wire logic clock,
  output logic packet_valid,
  output logic [31:0] packet_data
);
  initial
  begin
    packet_valid = 1'b0;
    packet_data = 32'h5a5a_a5a5;
  end
  task automatic send(input logic [31:0] w);
    @(negedge clock);
    packet_valid = 1'b1;
    packet_data = w;
    @(negedge clock);
    packet_valid = 1'b0;
    // scrambled idle data so a stray sample never looks valid
    packet_data = ~w;
  endtask
  task automatic put(input logic t, e, p, input logic [7:0] l, input logic [5:0] h);
    send({7'b0001101, t, e, 3'h0, p, 3'h0, l, 2'h0, (h == 6'h00) ? 6'h01 : h});
  endtask
endmodule // host_packet_model
`default_nettype wire

// >>> verification/receiver_shutdown_sequencer_tb_top.sv
/* bench for the shut-down sequencer: queued line values and probes.
   assumes UNIT_CYCLES shortened to 2. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module receiver_shutdown_sequencer_tb_top;
  localparam int unsigned U = 2;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic act = 1'b1;
  logic bat = 1'b0;
  logic ce = 1'b1;
  logic [7:0] on_l = 8'hc3;
  logic [7:0] off_l = 8'h3c;
  logic warm;
  logic eb;
  logic pv;
  logic [31:0] pd;
  logic [7:0] lines;
  logic [7:0] prev = 8'h00;
  logic busy, off, stb, smp;
  logic [15:0] e;
  logic [15:0] lq[$];
  logic bq[$];
  logic en[2], pb[2];
  logic [7:0] ln[2];
  logic [5:0] hd[2];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int plen = 0;
  initial forever #50 clock = ~clock;
  host_packet_model host_u (.clock, .packet_valid(pv), .packet_data(pd));
  receiver_shutdown_sequencer #(.UNIT_CYCLES(U)) dut_u (.clock, .reset,
    .clock_enable(ce), .packet_valid(pv), .packet_data(pd), .decoder_run_bit(run),
    .receiver_active(act), .receiver_on_lines(on_l), .receiver_off_lines(off_l),
    .battery_low_input(bat), .rx_control_lines(lines), .shutdown_busy(busy),
    .receiver_off(off), .warmup_permit(warm), .battery_sample_strobe(stb),
    .battery_low_sampled(smp));
  // outputs are looked at half a cycle after the edge that launches them
  always @(negedge clock)
  begin
    if (!reset && lines !== prev)
    begin
      e = lq.size() ? lq.pop_front() : 16'hxxxx;
      `CHK(lines, e[7:0])
      if (plen != 0) `CHK(cyc, plen)
      plen = e[15:8];
      cyc = 0;
    end
    cyc++;
    prev = lines;
    if (stb === 1'b1)
    begin
      // pop once, so a mismatch does not eat the next note
      eb = bq.size() ? bq.pop_front() : 1'bx;
      `CHK(smp, eb)
    end
  end
  task automatic cfg(input logic t, e, p, input logic [7:0] l, input logic [5:0] h);
    host_u.put(t, e, p, l, h);
    en[t] = e;
    pb[t] = p;
    ln[t] = l;
    hd[t] = h;
  endtask
  task automatic await(input logic v);
    int n;
    n = 0;
    while (off !== v && n < 400)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(n < 400, 1'b1)
  endtask
  task automatic shut(input bit early, input bit mid);
    @(negedge clock);
    bat = 1'($urandom);
    run = 1'b1;
    if (en[0])
    begin
      lq.push_back({8'(hd[0] * U + 1), ln[0]});
      if (pb[0]) bq.push_back(bat);
      if (en[1]) lq.push_back({8'(hd[1] * U + 1), ln[1]});
      if (en[1] && pb[1]) bq.push_back(bat);
    end
    lq.push_back({8'h00, off_l});
    lq.push_back({8'h00, on_l});
    @(negedge clock);
    run = 1'b0;
    if (mid) cfg(0, 1, 0, 8'h7e, 6'h02);
    if (early)
    begin
      // the falling run bit must be sampled before it rises again
      @(negedge clock);
      run = 1'b1;
      @(negedge clock);
      `CHK(warm, 1'b0)
    end
    await(1'b1);
    run = 1'b1;
    await(1'b0);
    `CHK(warm, 1'b1)
    repeat (3) @(negedge clock);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #(100 * 20000);
    fails++;
    summarize;
  end
  initial
  begin
    void'($urandom(32'he833ab6f));
    en = '{1'b0, 1'b0};
    lq.push_back(16'h00c3);
    repeat (16) @(negedge clock);
    reset = 1'b0;
    shut(0, 0);
    cfg(1, 1, 1, 8'h9a, 6'h05);
    shut(0, 0);
    for (int i = 0; i < 4; i++)
    begin
      cfg(0, 1, i[0], {2'b01, 6'($urandom)}, 6'($urandom % 63 + 1));
      cfg(1, i < 3, i[1], {2'b10, 6'($urandom)}, (i == 0) ? 6'h3f : 6'h01);
      shut(i == 2, 0);
    end
    cfg(0, 1, 1, 8'h55, 6'h04);
    host_u.send(32'h1c80_ff3f);
    shut(0, 1);
    shut(0, 0);
    // a frozen block must not see a run-bit pulse
    ce = 1'b0;
    @(negedge clock);
    run = 1'b0;
    repeat (4) @(negedge clock);
    run = 1'b1;
    @(negedge clock);
    ce = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(busy | off, 1'b0)
    act = 1'b0;
    run = 1'b0;
    repeat (5) @(negedge clock);
    `CHK(busy | off, 1'b0)
    run = 1'b1;
    act = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    en = '{1'b0, 1'b0};
    lq.push_back(16'h00c3);
    shut(0, 0);
    `CHK(lq.size(), 0)
    summarize;
  end
endmodule // receiver_shutdown_sequencer_tb_top
`default_nettype wire
